/* File: hdl/wdm_unit.sv */
// Purpose: data-movement execution unit (column scatter, fill, copy, swap,
//          offset distribute/collect, bit and digit move)
// Assumes: data memory answers a read one cycle after mem_rd_out is high
// Notes:   all checks are made before the first write of an execution
`timescale 1ns/10ps

// Functional notes
// [RULE1] low execution condition changes nothing
// [RULE2] source bit i goes to column of D+i
// [RULE3] bad or out-of-range column raises error
// [RULE4] equal flag reflects zero source word
// [RULE5] fill writes source into start..end inclusive
// [RULE6] fill range split or reversed raises error
// [RULE7] fill may write timer/counter present values
// [RULE8] copy S..S+N to D..D+N in order
// [RULE9] copy: bad count or range leaving area errors
// [RULE10] program keeps copy ranges from overlapping
// [RULE11] swap exchanges two words in one execution
// [RULE12] distribute writes source to base plus offset
// [RULE13] distribute: bad offset or area leave errors
// [RULE14] collect copies base plus offset into destination
// [RULE15] collect: bad offset or area leave errors
// [RULE16] bit move: low pair source, high destination
// [RULE17] bit numbers outside 00..15 raise error
// [RULE18] digit move wraps digits past the highest
// [RULE19] digit designator digits above 3 error
// [RULE20] bad indirect pointer raises error
// [RULE21] digits: source start, count-1, destination start
// [RULE22] an erroring execution writes no word
module wdm_unit (
   input  wire logic                      sys_clk_in,
   input  wire logic                      rst_in,
   input  wire logic                      start_in,
   input  wire logic                      exec_cond_in,
   input  wire wdm_pkg::wdm_op_type       op_in,
   input  wire logic [wdm_pkg::AW-1:0]    opr0_in,
   input  wire logic [wdm_pkg::AW-1:0]    opr1_in,
   input  wire logic [wdm_pkg::AW-1:0]    opr2_in,
   input  wire logic [2:0]                opr_imm_in,
   input  wire logic [2:0]                opr_ind_in,
   input  wire logic [wdm_pkg::DW-1:0]    mem_rdata_in,
   output logic                           mem_rd_out,
   output logic                           mem_wr_out,
   output logic      [wdm_pkg::AW-1:0]    mem_addr_out,
   output logic      [wdm_pkg::DW-1:0]    mem_wdata_out,
   output logic                           busy_out,
   output logic                           done_out,
   output logic                           error_flag_out,
   output logic                           equal_flag_out
);

   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      wdm_pkg::wdm_state_type            st;
      wdm_pkg::wdm_state_type            ret;
      wdm_pkg::wdm_op_type               op;
      logic [1:0]                        idx;
      logic                              ptr_done;
      logic [2:0]                        imm;
      logic [2:0]                        ind;
      logic [2:0][wdm_pkg::AW-1:0]       addr;
      logic [2:0][wdm_pkg::DW-1:0]       val;
      logic [wdm_pkg::AW-1:0]            cnt;
      logic [wdm_pkg::AW-1:0]            last;
      logic [wdm_pkg::AW-1:0]            off;
      logic                              err;
      logic                              src_zero;
      logic                              done;
      logic                              mem_rd;
      logic                              mem_wr;
      logic [wdm_pkg::AW-1:0]            mem_addr;
      logic [wdm_pkg::DW-1:0]            mem_wdata;
   } wdm_reg_type;

   wdm_reg_type q_q;
   wdm_reg_type q_d;

   logic [wdm_pkg::DW-1:0] num_sel;
   logic [wdm_pkg::VW-1:0] cv_val;
   logic                   cv_ok;
   logic                   chk_err;
   logic [wdm_pkg::AW-1:0] loff;
   logic [wdm_pkg::AW-1:0] llast;
   logic [wdm_pkg::AW-1:0] rd_addr;
   logic [wdm_pkg::AW-1:0] wr_addr;
   logic [wdm_pkg::DW-1:0] wdata;
   logic [8:0]             bit_src;
   logic [8:0]             bit_dst;
   logic [2:0]             vmask;

   // which operands are read as values rather than used as addresses
   function automatic logic [2:0] val_mask(input wdm_pkg::wdm_op_type op);
      case (op)
         wdm_pkg::word_to_column_op,
         wdm_pkg::offset_distribute_op: val_mask = 3'b101;
         wdm_pkg::offset_collect_op:    val_mask = 3'b010;
         wdm_pkg::bit_move_op,
         wdm_pkg::digit_move_op:        val_mask = 3'b011;
         default:                       val_mask = 3'b001;
      endcase
   endfunction : val_mask

   // two BCD digits: {ok, binary value}
   function automatic logic [8:0] bcd2(input logic [7:0] b);
      bcd2 = {(b[7:4] <= 4'h9) && (b[3:0] <= 4'h9),
              8'(b[7:4] * 4'ha) + {4'h0, b[3:0]}};
   endfunction : bcd2

   // range a..a+n must sit inside one existing area
   function automatic logic same_area(input logic [wdm_pkg::AW-1:0] a,
                                      input logic [wdm_pkg::AW-1:0] n);
      logic [2:0] ar;
      ar = wdm_pkg::area_of({1'b0, a});
      same_area = (ar != wdm_pkg::AREA_NONE) &&
                  (ar == wdm_pkg::area_of({1'b0, a} + {1'b0, n}));
   endfunction : same_area

   // ************************************************
   // numeric operand conversion and checks
   // ************************************************
   wdm_bcd_conv #(
      .DIGITS (4),
      .VW     (wdm_pkg::VW)
   ) u_bcd (
      .bcd_in    (num_sel),
      .value_out (cv_val),
      .ok_out    (cv_ok)
   );

   assign bit_src = bcd2(q_q.val[1][7:0]);  // RULE16
   assign bit_dst = bcd2(q_q.val[1][15:8]); // RULE16
   assign vmask   = val_mask(q_q.op);

   always_comb begin
      num_sel = q_q.val[1];
      chk_err = 1'b0;
      loff    = '0;
      llast   = '0;
      if (q_q.st == wdm_pkg::st_ptr_use) begin
         num_sel = mem_rdata_in;
      end else begin
         case (q_q.op)
            wdm_pkg::word_to_column_op: begin
               num_sel = q_q.val[2];
               chk_err = !cv_ok || cv_val > wdm_pkg::COL_MAX ||  // RULE3
                         !same_area(q_q.addr[1], wdm_pkg::COL_LAST);
               loff    = {2'b00, cv_val};
               llast   = wdm_pkg::COL_LAST;
            end
            wdm_pkg::block_fill_op: begin
               // any area qualifies, timer/counter values included RULE7
               chk_err = (wdm_pkg::area_of({1'b0, q_q.addr[1]}) !=
                          wdm_pkg::area_of({1'b0, q_q.addr[2]})) ||
                         (q_q.addr[1] > q_q.addr[2]) ||
                         !same_area(q_q.addr[1], '0);           // RULE6
               llast   = q_q.addr[2] - q_q.addr[1];
            end
            wdm_pkg::block_copy_op: begin
               num_sel = q_q.val[0];
               chk_err = !cv_ok || !same_area(q_q.addr[1], {2'b00, cv_val}) ||
                         !same_area(q_q.addr[2], {2'b00, cv_val}); // RULE9
               llast   = {2'b00, cv_val};
            end
            wdm_pkg::word_swap_op: begin
               llast = wdm_pkg::SWAP_LAST;
            end
            wdm_pkg::offset_distribute_op: begin
               num_sel = q_q.val[2];
               chk_err = !cv_ok || !same_area(q_q.addr[1], {2'b00, cv_val}); // RULE13
               loff    = {2'b00, cv_val};
            end
            wdm_pkg::offset_collect_op: begin
               chk_err = !cv_ok || !same_area(q_q.addr[0], {2'b00, cv_val}); // RULE15
               loff    = {2'b00, cv_val};
            end
            wdm_pkg::bit_move_op: begin
               chk_err = !bit_src[8] || bit_src[7:0] > 8'h0f ||
                         !bit_dst[8] || bit_dst[7:0] > 8'h0f;    // RULE17
            end
            default: begin
               chk_err = (q_q.val[1][3:0] > wdm_pkg::DIGIT_MAX) ||
                         (q_q.val[1][7:4] > wdm_pkg::DIGIT_MAX) ||
                         (q_q.val[1][11:8] > wdm_pkg::DIGIT_MAX); // RULE19
            end
         endcase
      end
   end

   // ************************************************
   // per-iteration addresses and write data
   // ************************************************
   always_comb begin
      logic [1:0] sd;
      logic [1:0] dd;
      sd      = '0;
      dd      = '0;
      rd_addr = q_q.addr[2];
      wr_addr = q_q.addr[2];
      wdata   = mem_rdata_in;
      case (q_q.op)
         wdm_pkg::word_to_column_op: begin
            rd_addr = q_q.addr[1] + q_q.cnt;
            wr_addr = rd_addr;
            wdata[q_q.off[3:0]] = q_q.val[0][q_q.cnt[3:0]];       // RULE2
         end
         wdm_pkg::block_fill_op: begin
            rd_addr = q_q.addr[1] + q_q.cnt;
            wr_addr = rd_addr;
            wdata   = q_q.val[0];                                 // RULE5
         end
         wdm_pkg::block_copy_op: begin
            // ascending order; overlap is kept out by the program RULE10
            rd_addr = q_q.addr[1] + q_q.cnt;                      // RULE8
            wr_addr = q_q.addr[2] + q_q.cnt;
         end
         wdm_pkg::word_swap_op: begin
            // first pass moves word 2 into word 1, second writes saved word 1
            rd_addr = q_q.addr[1];
            wr_addr = (q_q.cnt == '0) ? q_q.addr[0] : q_q.addr[1]; // RULE11
            wdata   = (q_q.cnt == '0) ? mem_rdata_in : q_q.val[0];
         end
         wdm_pkg::offset_distribute_op: begin
            rd_addr = q_q.addr[1] + q_q.off;                      // RULE12
            wr_addr = rd_addr;
            wdata   = q_q.val[0];
         end
         wdm_pkg::offset_collect_op: begin
            rd_addr = q_q.addr[0] + q_q.off;                      // RULE14
            wr_addr = q_q.addr[2];
         end
         wdm_pkg::bit_move_op: begin
            wdata[bit_dst[3:0]] = q_q.val[0][bit_src[3:0]];       // RULE16
         end
         default: begin
            for (int k = 0; k < 4; k++) begin
               if (2'(k) <= q_q.val[1][5:4]) begin                // RULE21
                  sd = q_q.val[1][1:0] + 2'(k);                   // RULE18
                  dd = q_q.val[1][9:8] + 2'(k);
                  wdata[4*dd+:4] = q_q.val[0][4*sd+:4];
               end
            end
         end
      endcase
   end

   // ************************************************
   // sequencer
   // ************************************************
   always_comb begin
      q_d        = q_q;
      q_d.done   = 1'b0;
      q_d.mem_rd = 1'b0;
      q_d.mem_wr = 1'b0;
      case (q_q.st)
         wdm_pkg::st_idle: begin
            if (start_in && exec_cond_in) begin
               q_d.st       = wdm_pkg::st_fetch;
               q_d.op       = op_in;
               q_d.addr     = {opr2_in, opr1_in, opr0_in};
               q_d.val      = {opr2_in, opr1_in, opr0_in};
               q_d.imm      = opr_imm_in;
               q_d.ind      = opr_ind_in;
               q_d.idx      = '0;
               q_d.ptr_done = 1'b0;
               q_d.cnt      = '0;
               q_d.err      = 1'b0;
            end else if (start_in) begin
               q_d.done = 1'b1;                                   // RULE1
            end
         end
         wdm_pkg::st_fetch: begin
            if (q_q.idx == 2'h3) begin
               q_d.st = wdm_pkg::st_check;
            end else if (q_q.ind[q_q.idx] && !q_q.ptr_done) begin
               q_d.mem_rd   = 1'b1;
               q_d.mem_addr = q_q.addr[q_q.idx];
               q_d.st       = wdm_pkg::st_wait;
               q_d.ret      = wdm_pkg::st_ptr_use;
            end else if (vmask[q_q.idx] && !q_q.imm[q_q.idx]) begin
               q_d.mem_rd   = 1'b1;
               q_d.mem_addr = q_q.addr[q_q.idx];
               q_d.st       = wdm_pkg::st_wait;
               q_d.ret      = wdm_pkg::st_val_use;
            end else begin
               q_d.idx      = q_q.idx + 2'h1;
               q_d.ptr_done = 1'b0;
            end
         end
         wdm_pkg::st_wait: begin
            q_d.st = q_q.ret;
         end
         wdm_pkg::st_ptr_use: begin
            if (!cv_ok || cv_val >= wdm_pkg::MEM_WORDS) begin
               q_d.err = 1'b1;                                    // RULE20
               q_d.st  = wdm_pkg::st_done;
            end else begin
               q_d.addr[q_q.idx] = wdm_pkg::MEM_BASE + {2'b00, cv_val};
               q_d.ptr_done      = 1'b1;
               q_d.st            = wdm_pkg::st_fetch;
            end
         end
         wdm_pkg::st_val_use: begin
            q_d.val[q_q.idx] = mem_rdata_in;
            q_d.idx          = q_q.idx + 2'h1;
            q_d.ptr_done     = 1'b0;
            q_d.st           = wdm_pkg::st_fetch;
         end
         wdm_pkg::st_check: begin
            q_d.err  = chk_err;
            q_d.off  = loff;
            q_d.last = llast;
            // failing checks skip every write RULE22
            q_d.st   = chk_err ? wdm_pkg::st_done : wdm_pkg::st_loop_rd;
            if (!chk_err && (q_q.op == wdm_pkg::word_to_column_op ||
                             q_q.op == wdm_pkg::offset_distribute_op)) begin
               q_d.src_zero = (q_q.val[0] == '0);                 // RULE4
            end
         end
         wdm_pkg::st_loop_rd: begin
            q_d.mem_rd   = 1'b1;
            q_d.mem_addr = rd_addr;
            q_d.st       = wdm_pkg::st_wait;
            q_d.ret      = wdm_pkg::st_loop_wr;
         end
         wdm_pkg::st_loop_wr: begin
            q_d.mem_wr    = 1'b1;
            q_d.mem_addr  = wr_addr;
            q_d.mem_wdata = wdata;
            if (q_q.cnt == q_q.last) begin
               q_d.st = wdm_pkg::st_done;
            end else begin
               q_d.cnt = q_q.cnt + 16'h0001;
               q_d.st  = wdm_pkg::st_loop_rd;
            end
         end
         default: begin
            q_d.done = 1'b1;
            q_d.st   = wdm_pkg::st_idle;
         end
      endcase
   end

   // reset clears everything; st_idle is code zero
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         q_q <= '0;
      end else begin
         q_q <= q_d;
      end
   end

   assign mem_rd_out     = q_q.mem_rd;
   assign mem_wr_out     = q_q.mem_wr;
   assign mem_addr_out   = q_q.mem_addr;
   assign mem_wdata_out  = q_q.mem_wdata;
   assign busy_out       = (q_q.st != wdm_pkg::st_idle);
   assign done_out       = q_q.done;
   assign error_flag_out = q_q.err;
   assign equal_flag_out = q_q.src_zero;

   // ************************************************
   // assertions
   // ************************************************
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   logic col_bit;
   assign col_bit = q_q.val[0][q_q.cnt[3:0]];

   sequence s_chk_ok(wdm_pkg::wdm_op_type op);
      q_q.st == wdm_pkg::st_check && q_q.op == op && !chk_err;
   endsequence
   sequence s_chk_bad;
      q_q.st == wdm_pkg::st_check && chk_err;
   endsequence

   a_skip_idle: assert property (q_q.st == wdm_pkg::st_idle && start_in && !exec_cond_in
      |=> done_out && !busy_out && !mem_wr_out && $stable(error_flag_out)
          && $stable(equal_flag_out)) else $error("skipped op changed state"); // RULE1
   a_column_bit: assert property (q_q.st == wdm_pkg::st_loop_wr
      && q_q.op == wdm_pkg::word_to_column_op
      |=> mem_wr_out && mem_wdata_out[q_q.off[3:0]] == $past(col_bit))
      else $error("column bit wrong"); // RULE2
   a_column_range: assert property (q_q.st == wdm_pkg::st_check
      && q_q.op == wdm_pkg::word_to_column_op && cv_val > wdm_pkg::COL_MAX
      |=> error_flag_out) else $error("bad column not flagged"); // RULE3
   a_equal_src: assert property (s_chk_ok(wdm_pkg::offset_distribute_op)
      |=> equal_flag_out == (q_q.val[0] == '0)) else $error("equal flag wrong"); // RULE4
   a_fill_data: assert property (mem_wr_out && q_q.op == wdm_pkg::block_fill_op
      |-> mem_wdata_out == q_q.val[0]) else $error("fill data wrong"); // RULE5
   a_fill_order: assert property (q_q.st == wdm_pkg::st_check
      && q_q.op == wdm_pkg::block_fill_op && q_q.addr[1] > q_q.addr[2]
      |=> error_flag_out ##1 done_out) else $error("reversed fill accepted"); // RULE6
   a_copy_pair: assert property (mem_wr_out && q_q.op == wdm_pkg::block_copy_op
      |-> 16'(mem_addr_out - q_q.addr[2]) == 16'($past(mem_addr_out, 2) - q_q.addr[1]))
      else $error("copy offset mismatch"); // RULE8
   a_copy_count: assert property (q_q.st == wdm_pkg::st_check
      && q_q.op == wdm_pkg::block_copy_op && !cv_ok
      |=> error_flag_out) else $error("non-bcd count accepted"); // RULE9
   a_swap_steps: assert property (s_chk_ok(wdm_pkg::word_swap_op)
      |-> ##4 (mem_wr_out && mem_addr_out == q_q.addr[0])
          ##3 (mem_wr_out && mem_addr_out == q_q.addr[1] && mem_wdata_out == q_q.val[0]))
      else $error("swap sequence wrong"); // RULE11
   a_ptr_error: assert property (q_q.st == wdm_pkg::st_ptr_use && !cv_ok
      |=> error_flag_out ##1 done_out) else $error("bad pointer not flagged"); // RULE20
   a_err_nowrite: assert property (s_chk_bad
      |=> !mem_wr_out ##1 (done_out && !mem_wr_out))
      else $error("write after error"); // RULE22

endmodule : wdm_unit

/* File: hdl/wdm_pkg.sv */
// Purpose: shared constants and types of the word data-movement unit
// Assumes: flat 16-bit word address space split into fixed data areas
// Notes:   area bounds are plain defaults; adjust to the real memory map
package wdm_pkg;

   // ************************************************
   // widths and limits
   // ************************************************
   localparam int AW = 16;
   localparam int DW = 16;
   localparam int VW = 14;
   localparam logic [VW-1:0] COL_MAX   = 14'h000f;
   localparam logic [3:0]    DIGIT_MAX = 4'h3;
   localparam logic [AW-1:0] COL_LAST  = 16'h000f;
   localparam logic [AW-1:0] SWAP_LAST = 16'h0001;

   // ************************************************
   // data areas; the last one is the data memory area
   // ************************************************
   localparam int AREA_NUM = 5;
   localparam logic [2:0] AREA_NONE = 3'h7;
   localparam logic [AW-1:0] AREA_BASE [AREA_NUM] =
      '{16'h0000, 16'h0200, 16'h0400, 16'h0800, 16'h1000};
   localparam logic [AW-1:0] AREA_LAST [AREA_NUM] =
      '{16'h01ff, 16'h03ff, 16'h07ff, 16'h0fff, 16'h17cf};
   localparam logic [AW-1:0] MEM_BASE  = 16'h1000;
   localparam logic [VW-1:0] MEM_WORDS = 14'h07d0;

   // ************************************************
   // operations and states
   // ************************************************
   typedef enum logic [2:0] {
      word_to_column_op    = 3'b000,
      block_fill_op        = 3'b001,
      block_copy_op        = 3'b010,
      word_swap_op         = 3'b011,
      offset_distribute_op = 3'b100,
      offset_collect_op    = 3'b101,
      bit_move_op          = 3'b110,
      digit_move_op        = 3'b111
   } wdm_op_type;

   typedef enum logic [3:0] {
      st_idle    = 4'b0000,
      st_fetch   = 4'b0001,
      st_wait    = 4'b0010,
      st_ptr_use = 4'b0011,
      st_val_use = 4'b0100,
      st_check   = 4'b0101,
      st_loop_rd = 4'b0110,
      st_loop_wr = 4'b0111,
      st_done    = 4'b1000
   } wdm_state_type;

   function automatic logic [2:0] area_of(input logic [AW:0] a);
      area_of = AREA_NONE;
      for (int i = 0; i < AREA_NUM; i++) begin
         if (a >= {1'b0, AREA_BASE[i]} && a <= {1'b0, AREA_LAST[i]}) begin
            area_of = 3'(i);
         end
      end
   endfunction : area_of

endpackage : wdm_pkg

/* File: hdl/wdm_bcd_conv.sv */
// Purpose: combinational packed-BCD to binary converter
// Assumes: digits packed four bits each, least significant digit lowest
// Notes:   value_out is meaningless when ok_out is low
`timescale 1ns/10ps
module wdm_bcd_conv #(
   parameter int DIGITS = 4,
   parameter int VW     = 14
) (
   input  wire logic [4*DIGITS-1:0] bcd_in,
   output logic      [VW-1:0]       value_out,
   output logic                     ok_out
);

   localparam logic [VW-1:0] TEN = VW'(4'ha);
   logic [DIGITS-1:0] dig_ok;

   genvar g;
   generate
      for (g = 0; g < DIGITS; g++) begin : g_dig
         assign dig_ok[g] = (bcd_in[4*g+:4] <= 4'h9);
      end
   endgenerate

   assign ok_out = &dig_ok;

   always_comb begin
      value_out = '0;
      for (int i = DIGITS - 1; i >= 0; i--) begin
         value_out = VW'(value_out * TEN) + VW'(bcd_in[4*i+:4]);
      end
   end

endmodule : wdm_bcd_conv

/* File: test/wdm_mem_model.sv */
// Purpose: word data memory standing beside the movement unit
// Assumes: read data is wanted in the cycle after the read strobe
// Notes:   read data outside that cycle is inverted so a late sample fails
`timescale 1ns/10ps
module wdm_mem_model (
   input  wire logic        sys_clk_in,
   input  wire logic        rd_in,
   input  wire logic        wr_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [15:0] wdata_in,
   output logic      [15:0] rdata_out
);
   // ****************************************
   // storage, one-cycle read answer
   // ****************************************
   logic [15:0] m [0:16'h17ff];
   logic [15:0] rd_q = 16'h0000;
   logic        vld_q = 1'b0;
   // plain always: the bench preloads words between operations
   always @(posedge sys_clk_in) begin
      vld_q <= rd_in;
      if (rd_in) begin
         rd_q <= m[addr_in];
      end
      if (wr_in) begin
         m[addr_in] <= wdata_in;
      end
   end
   assign rdata_out = vld_q ? rd_q : ~rd_q;
endmodule : wdm_mem_model

/* File: test/wdm_unit_tb.sv */
// Purpose: self-checking bench of the data-movement unit
// Assumes: memory model answers reads one cycle after the strobe
// Notes:   memory is preloaded and inspected through the model's array
`timescale 1ns/10ps
module wdm_unit_tb;
   // ****************************************
   // stimulus, instances, helpers
   // ****************************************
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic start_in = 1'b0;
   logic exec_cond_in = 1'b0;
   wdm_pkg::wdm_op_type op_in = wdm_pkg::block_fill_op;
   logic [15:0] opr0_in = 16'h0000;
   logic [15:0] opr1_in = 16'h0000;
   logic [15:0] opr2_in = 16'h0000;
   logic [2:0]  opr_imm_in = 3'h0;
   logic [2:0]  opr_ind_in = 3'h0;
   logic [2:0]  ind_v = 3'h0;
   logic [15:0] mem_rdata_in, mem_addr_out, mem_wdata_out;
   logic mem_rd_out, mem_wr_out, busy_out, done_out, error_flag_out, equal_flag_out;
   int num_errors = 0;
   int cmp_count = 0;
   int waits;
   always #12.5 sys_clk_in = ~sys_clk_in;
   wdm_unit i_dut (.sys_clk_in, .rst_in, .start_in, .exec_cond_in, .op_in, .opr0_in,
      .opr1_in, .opr2_in, .opr_imm_in, .opr_ind_in, .mem_rdata_in, .mem_rd_out,
      .mem_wr_out, .mem_addr_out, .mem_wdata_out, .busy_out, .done_out,
      .error_flag_out, .equal_flag_out);
   wdm_mem_model i_mem (.sys_clk_in, .rd_in(mem_rd_out), .wr_in(mem_wr_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic err(input logic e);
      chk(16'(error_flag_out), 16'(e));
   endtask : err
   // one request, then a bounded wait for done, sampled 1 ns past the edge
   task automatic run(input wdm_pkg::wdm_op_type op, input logic [15:0] a, input logic [15:0] b,
                      input logic [15:0] c, input logic [2:0] imm, input logic ex);
      @(posedge sys_clk_in);
      start_in <= 1'b1;
      exec_cond_in <= ex;
      op_in <= op;
      opr0_in <= a;
      opr1_in <= b;
      opr2_in <= c;
      opr_imm_in <= imm;
      opr_ind_in <= ind_v;
      @(posedge sys_clk_in);
      start_in <= 1'b0;
      waits = 0;
      #1;
      chk(16'(busy_out), 16'(ex));
      while (done_out !== 1'b1 && waits < 300) begin
         @(posedge sys_clk_in);
         #1;
         waits++;
      end
      if (waits == 300) begin
         num_errors++;
         complete_run();
      end
   endtask : run
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_skip();
      i_mem.m[16'h1000] = 16'h5555;
      run(wdm_pkg::block_fill_op, 16'h0000, 16'h1000, 16'h1000, 3'h1, 1'b0);
      chk(16'(waits), 16'h0000);
      chk(i_mem.m[16'h1000], 16'h5555);
      $display("test skip done");
   endtask : t_skip
   task automatic t_col();
      logic [15:0] s = 16'h00f0;
      for (int i = 0; i < 16; i++)
         i_mem.m[16'h1100 + i] = 16'hffff;
      run(wdm_pkg::word_to_column_op, s, 16'h1100, 16'h0003, 3'h5, 1'b1);
      for (int i = 0; i < 16; i++)
         chk(i_mem.m[16'h1100 + i], 16'hfff7 | {12'h000, s[i], 3'h0});
      chk(16'(equal_flag_out), 16'h0000);
      run(wdm_pkg::word_to_column_op, 16'h0000, 16'h1100, 16'h0016, 3'h5, 1'b1);
      err(1'b1);
      chk(i_mem.m[16'h1100], 16'hfff7);
      $display("test column done");
   endtask : t_col
   task automatic t_fill();
      i_mem.m[16'h0803] = 16'h0000;
      run(wdm_pkg::block_fill_op, 16'h1234, 16'h0800, 16'h0802, 3'h1, 1'b1);
      for (int i = 0; i < 4; i++)
         chk(i_mem.m[16'h0800 + i], i < 3 ? 16'h1234 : 16'h0000);
      run(wdm_pkg::block_fill_op, 16'h9999, 16'h0802, 16'h0800, 3'h1, 1'b1);
      err(1'b1);
      chk(i_mem.m[16'h0800], 16'h1234);
      run(wdm_pkg::block_fill_op, 16'h9999, 16'h01ff, 16'h0200, 3'h1, 1'b1);
      err(1'b1);
      $display("test fill done");
   endtask : t_fill
   task automatic t_copy();
      for (int i = 0; i < 4; i++)
         i_mem.m[16'h1010 + i] = 16'h0a00 + 16'(i);
      i_mem.m[16'h1023] = 16'h0000;
      run(wdm_pkg::block_copy_op, 16'h0002, 16'h1010, 16'h1020, 3'h1, 1'b1);
      for (int i = 0; i < 4; i++)
         chk(i_mem.m[16'h1020 + i], i < 3 ? 16'h0a00 + 16'(i) : 16'h0000);
      run(wdm_pkg::block_copy_op, 16'h000a, 16'h1010, 16'h1020, 3'h1, 1'b1);
      err(1'b1);
      run(wdm_pkg::block_copy_op, 16'h0005, 16'h01fd, 16'h1040, 3'h1, 1'b1);
      err(1'b1);
      i_mem.m[16'h1030] = 16'h1111;
      i_mem.m[16'h1031] = 16'h2222;
      run(wdm_pkg::word_swap_op, 16'h1030, 16'h1031, 16'h0000, 3'h0, 1'b1);
      chk(i_mem.m[16'h1030], 16'h2222);
      chk(i_mem.m[16'h1031], 16'h1111);
      $display("test copy done");
   endtask : t_copy
   task automatic t_offs();
      i_mem.m[16'h104c] = 16'hffff;
      i_mem.m[16'h1045] = 16'h4bcd;
      run(wdm_pkg::offset_distribute_op, 16'h0000, 16'h1040, 16'h0012, 3'h5, 1'b1);
      chk(i_mem.m[16'h104c], 16'h0000);
      chk(16'(equal_flag_out), 16'h0001);
      run(wdm_pkg::offset_distribute_op, 16'h7777, 16'h01f0, 16'h0020, 3'h5, 1'b1);
      err(1'b1);
      run(wdm_pkg::offset_collect_op, 16'h1040, 16'h0005, 16'h1060, 3'h2, 1'b1);
      chk(i_mem.m[16'h1060], 16'h4bcd);
      run(wdm_pkg::offset_collect_op, 16'h1040, 16'h001a, 16'h1061, 3'h2, 1'b1);
      err(1'b1);
      $display("test offset done");
   endtask : t_offs
   task automatic t_bits();
      i_mem.m[16'h1070] = 16'h0000;
      i_mem.m[16'h1071] = 16'h0000;
      run(wdm_pkg::bit_move_op, 16'h0001, 16'h1500, 16'h1070, 3'h3, 1'b1);
      chk(i_mem.m[16'h1070], 16'h8000);
      run(wdm_pkg::bit_move_op, 16'h0001, 16'h0016, 16'h1070, 3'h3, 1'b1);
      err(1'b1);
      run(wdm_pkg::digit_move_op, 16'h4321, 16'h0313, 16'h1071, 3'h3, 1'b1);
      chk(i_mem.m[16'h1071], 16'h4001);
      run(wdm_pkg::digit_move_op, 16'h4321, 16'h0004, 16'h1071, 3'h3, 1'b1);
      err(1'b1);
      ind_v = 3'h6;
      i_mem.m[16'h1080] = 16'h0a00;
      run(wdm_pkg::block_fill_op, 16'h2222, 16'h1080, 16'h1080, 3'h1, 1'b1);
      err(1'b1);
      i_mem.m[16'h1080] = 16'h0081;
      run(wdm_pkg::block_fill_op, 16'h2222, 16'h1080, 16'h1080, 3'h1, 1'b1);
      chk(i_mem.m[16'h1051], 16'h2222);
      ind_v = 3'h0;
      $display("test bit digit indirect done");
   endtask : t_bits
   initial begin
      repeat (6) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      t_skip();
      t_col();
      t_fill();
      t_copy();
      t_offs();
      t_bits();
      complete_run();
   end
endmodule : wdm_unit_tb
